// ---- design/charger_alert_adc.sv ----
// register bank, host alert line and converter sequencing of the charger
// assumes event sources and the converter sample are on the system clock
`timescale 1ns/100ps
`default_nettype none
`include "charger_defines.svh"

// Functional notes
// [RQ1] alert pulled low when any flag set
// [RQ2] alert released once all flags cleared
// [RQ3] repeat option pulses alert every 2 s
// [RQ4] host reads event registers in ascending order
// [RQ5] repeat event while reading gives no edge
// [RQ6] rearm releases alert 2 ms, then low
// [RQ7] input limit is smaller of field, pin
// [RQ8] host selects channel and sets start bit
// [RQ9] after 200 ms done flag set, busy cleared
// [RQ10] result split into high and low bytes
// [RQ11] voltage channels weigh 25, 10, 5 mV
// [RQ12] thermistor channels weigh 0.25 percent each
// [RQ13] bus current 50 mA, scaled below 400
// [RQ14] battery current 50 mA, scaled by setting
// [RQ15] junction temperature 2 degrees, minus 40
// [RQ16] host sets currents high before measuring
// [RQ17] slave address then direction bit after start
// [RQ18] write: index byte then data byte
// [RQ19] status bit shows converter active or idle
// [RQ20] conversion done flag also drives alert
module charger_alert_adc #(
	parameter logic [27:0] CONVERSION_CYCLES = 28'(`CONVERSION_TIME_MS * `SYS_CLK_KHZ),
	parameter logic [27:0] REPEAT_CYCLES     = 28'(`REPEAT_TIME_S * 1000 * `SYS_CLK_KHZ),
	parameter logic [27:0] REARM_CYCLES      = 28'(`REARM_GAP_TIME_MS * `SYS_CLK_KHZ)
) (
	input  wire logic                      CLK_SYS,
	input  wire logic                      SYS_RST,
	input  wire logic                      SCL,
	input  wire logic                      SDA_IN,
	output var  logic                      SDA_OUT,
	output var  logic                      SDA_OE,
	output var  logic                      ALERT_OUT,
	output var  logic                      ALERT_OE,
	input  wire logic [7:1]                EVENT_SET,
	input  wire logic [15:0]               ADC_SAMPLE,
	output var  logic [3:0]                ADC_CHANNEL,
	input  wire logic [1:0]                PIN_CURRENT_CAP,
	output var  logic [1:0]                INPUT_LIMIT
);
	import charger_pkg::*;

	localparam int SYNC_W = 7;

	charger_pkg::alert_state_type alert_state;
	logic [SYNC_W-1:0]           sync1;
	logic [SYNC_W-1:0]           sync2;
	logic [4:0]                  sync_prev;
	logic                        scl_s;
	logic                        sda_s;
	logic [1:0]                  pin_cap_s;
	logic                        start_det;
	logic                        stop_det;
	logic                        index_ev;
	logic                        write_ev;
	logic                        read_ev;
	logic                        link_clear;
	logic                        link_rst;
	logic                        link_sda_oe;
	logic [7:0]                  index_byte;
	logic [7:0]                  write_byte;
	logic                        index_toggle;
	logic                        write_toggle;
	logic                        read_toggle;
	logic [7:0]                  ptr;
	logic [7:0]                  rd_byte;
	logic [7:0]                  operating_control_a;
	logic [7:0]                  charge_control_b;
	logic [7:0]                  converter_control;
	logic [7:0]                  event_flags_five;
	logic [7:0]                  next_flags;
	logic [15:0]                 result;
	logic                        conv_busy;
	logic [27:0]                 conv_cnt;
	logic                        start_req;
	logic                        rearm_req;
	logic                        flags_clear;
	logic                        conv_done;
	logic                        pending;
	logic                        read_seen;
	logic [27:0]                 alert_cnt;
	logic [1:0]                  cap_select;

	function automatic logic [7:0] reg_read(input logic [7:0] idx,
		input logic [7:0] op_a, input logic [7:0] ch_b, input logic [7:0] cc,
		input logic busy, input logic [15:0] res, input logic [7:0] ev);
		begin
			case (idx)
				`REG_OPERATING_CONTROL_A: reg_read = op_a;
				`REG_CHARGE_CONTROL_B:    reg_read = ch_b;
				`REG_CONVERTER_CONTROL:   reg_read = cc;
				`REG_DEVICE_STATUS:       reg_read = {7'h00, busy};
				`REG_RESULT_HIGH:         reg_read = res[15:8];
				`REG_RESULT_LOW:          reg_read = res[7:0];
				`REG_EVENT_FLAGS_FIVE:    reg_read = ev;
				default:                  reg_read = 8'h00;
			endcase
		end
	endfunction

	function automatic logic in_event_range(input logic [7:0] idx);
		begin
			in_event_range = (idx >= `REG_EVENT_FIRST) && (idx <= `REG_EVENT_LAST);
		end
	endfunction

	host_link u_link (
		.scl          (SCL),
		.link_clear   (link_clear),
		.link_rst     (link_rst),
		.sda_in       (SDA_IN),
		.sda_oe       (link_sda_oe),
		.rd_byte      (rd_byte),
		.index_byte   (index_byte),
		.write_byte   (write_byte),
		.index_toggle (index_toggle),
		.write_toggle (write_toggle),
		.read_toggle  (read_toggle)
	);

	assign SDA_OUT   = 1'b0;
	assign SDA_OE    = link_sda_oe;
	assign ALERT_OUT = 1'b0;

	// two-stage synchronisers for pins and link toggles
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
			logic raw;
			if (g == 0) begin : g_scl
				assign raw = SCL;
			end else if (g == 1) begin : g_sda
				assign raw = SDA_IN;
			end else if (g == 2) begin : g_idx
				assign raw = index_toggle;
			end else if (g == 3) begin : g_wr
				assign raw = write_toggle;
			end else if (g == 4) begin : g_rd
				assign raw = read_toggle;
			end else begin : g_pin
				assign raw = PIN_CURRENT_CAP[g-5];
			end
			always_ff @(posedge CLK_SYS) begin
				if (SYS_RST) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
				end else begin
					sync1[g] <= raw;
					sync2[g] <= sync1[g];
				end
			end
		end
	endgenerate

	assign scl_s     = sync2[0];
	assign sda_s     = sync2[1];
	assign pin_cap_s = sync2[6:5];

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			sync_prev <= 5'h00; // matches cleared sync2, so no false toggle or start after reset
		end else begin
			sync_prev <= sync2[4:0];
		end
	end

	assign start_det = scl_s && sync_prev[0] && sync_prev[1] && !sda_s;
	assign stop_det  = scl_s && sync_prev[0] && !sync_prev[1] && sda_s;
	assign index_ev  = sync2[2] ^ sync_prev[2];
	assign write_ev  = sync2[3] ^ sync_prev[3];
	assign read_ev   = sync2[4] ^ sync_prev[4];

	// link engine held clear from each start or stop until the clock goes low
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			link_clear <= 1'b1;
			link_rst   <= 1'b1;
		end else begin
			link_rst <= 1'b0;
			if (start_det || stop_det) begin
				link_clear <= 1'b1;
			end else if (!scl_s) begin
				link_clear <= 1'b0;
			end
		end
	end

	// index pointer loads from the index byte and advances after every data byte written or sent
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ptr <= `RESET_BYTE;
		end else if (index_ev) begin
			ptr <= index_byte; // [RQ18]
		end else if (write_ev || read_ev) begin
			ptr <= ptr + 8'h01;
		end
	end

	// read byte is quasi-static for the link: refreshed long before the next byte
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rd_byte <= `RESET_BYTE;
		end else begin
			rd_byte <= reg_read(ptr, operating_control_a, charge_control_b,
				converter_control, conv_busy, result, event_flags_five);
		end
	end

	assign start_req   = write_ev && (ptr == `REG_CONVERTER_CONTROL)
		&& write_byte[`BIT_CONV_START];
	assign rearm_req   = write_ev && (ptr == `REG_OPERATING_CONTROL_A)
		&& write_byte[`BIT_ALERT_REARM];
	assign flags_clear = read_ev && (ptr == `REG_EVENT_FLAGS_FIVE);

	// writable control registers; rearm and start bits read back as zero
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			operating_control_a <= `RESET_BYTE;
			charge_control_b    <= `RESET_BYTE;
			converter_control   <= `RESET_BYTE;
		end else if (write_ev) begin
			case (ptr)
				`REG_OPERATING_CONTROL_A: begin
					operating_control_a <= write_byte & ~(8'h01 << `BIT_ALERT_REARM);
				end
				`REG_CHARGE_CONTROL_B: begin
					charge_control_b <= write_byte;
				end
				`REG_CONVERTER_CONTROL: begin
					converter_control <= write_byte & ~(8'h01 << `BIT_CONV_START); // [RQ8]
				end
				default: begin
				end
			endcase
		end
	end

	assign cap_select = charge_control_b[`BIT_CAP_SELECT_MSB:`BIT_CAP_SELECT_LSB];

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			INPUT_LIMIT <= 2'h0;
			ADC_CHANNEL <= 4'h0;
		end else begin
			INPUT_LIMIT <= (cap_select < pin_cap_s) ? cap_select : pin_cap_s; // [RQ7]
			ADC_CHANNEL <= converter_control[`BIT_CHANNEL_MSB:`BIT_CHANNEL_LSB];
		end
	end

	// conversion timer; a start while busy restarts the conversion
	assign conv_done = conv_busy && (conv_cnt == CONVERSION_CYCLES - 28'h1);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			conv_busy <= 1'b0;
			conv_cnt  <= 28'h0;
			result    <= `RESET_WORD;
		end else if (start_req) begin
			conv_busy <= 1'b1; // [RQ19]
			conv_cnt  <= 28'h0;
		end else if (conv_done) begin
			conv_busy <= 1'b0; // [RQ9]
			result    <= ADC_SAMPLE; // [RQ10]
		end else if (conv_busy) begin
			conv_cnt <= conv_cnt + 28'h1;
		end
	end
	// code is raw; per-channel weights [RQ11] [RQ12] [RQ13] [RQ14] [RQ15] are the host's

	// event flags clear on read; a set in the same cycle wins
	always_comb begin
		next_flags = event_flags_five;
		if (flags_clear) begin
			next_flags = 8'h00;
		end
		next_flags = next_flags | {EVENT_SET, 1'b0};
		if (conv_done) begin
			next_flags[`BIT_CONV_DONE] = 1'b1; // [RQ9]
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			event_flags_five <= `RESET_BYTE;
		end else begin
			event_flags_five <= next_flags;
		end
	end

	assign pending = |event_flags_five; // [RQ20]

	// a host read inside the event block stops the repeat reminder
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			read_seen <= 1'b0;
		end else if (alert_state == ALERT_IDLE) begin
			read_seen <= 1'b0;
		end else if (read_ev && in_event_range(ptr)) begin
			read_seen <= 1'b1; // [RQ4]
		end
	end

	// line stays low while new events arrive, so they make no fresh edge
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			alert_state <= ALERT_IDLE;
			alert_cnt   <= 28'h0;
		end else begin
			case (alert_state)
				ALERT_IDLE: begin
					alert_cnt <= 28'h0;
					if (pending) begin
						alert_state <= ALERT_LOW; // [RQ1]
					end
				end
				ALERT_LOW: begin
					alert_cnt <= alert_cnt + 28'h1; // [RQ5]
					if (!pending) begin
						alert_state <= ALERT_IDLE; // [RQ2]
					end else if (rearm_req) begin
						alert_state <= ALERT_GAP; // [RQ6]
						alert_cnt   <= 28'h0;
					end else if (operating_control_a[`BIT_ALERT_REPEAT] && !read_seen
						&& alert_cnt >= REPEAT_CYCLES - 28'h1) begin
						alert_state <= ALERT_GAP; // [RQ3]
						alert_cnt   <= 28'h0;
					end
				end
				ALERT_GAP: begin
					alert_cnt <= alert_cnt + 28'h1;
					if (!pending) begin
						alert_state <= ALERT_IDLE; // [RQ2]
					end else if (alert_cnt >= REARM_CYCLES - 28'h1) begin
						alert_state <= ALERT_LOW; // [RQ6]
						alert_cnt   <= 28'h0;
					end
				end
				default: begin
					alert_state <= ALERT_IDLE;
					alert_cnt   <= 28'h0;
				end
			endcase
		end
	end

	assign ALERT_OE = (alert_state == ALERT_LOW);

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	alert_assert_a: assert property ((alert_state == ALERT_IDLE) && pending |=> ALERT_OE) // [RQ1]
		else $error("alert not driven after event");
	alert_release_a: assert property (!pending |=> !ALERT_OE) // [RQ2]
		else $error("alert held with no pending flag");
	repeat_gap_a: assert property (ALERT_OE && pending && !rearm_req && !read_seen // [RQ3]
		&& operating_control_a[`BIT_ALERT_REPEAT] && alert_cnt == REPEAT_CYCLES - 28'h1
		|=> !ALERT_OE [*2])
		else $error("repeat reminder did not release alert");
	rearm_gap_a: assert property (ALERT_OE && pending && rearm_req |=> !ALERT_OE) // [RQ6]
		else $error("rearm did not release alert");
	gap_end_a: assert property ((alert_state == ALERT_GAP) && pending // [RQ6]
		&& alert_cnt == REARM_CYCLES - 28'h1 |=> ALERT_OE)
		else $error("alert not reasserted after gap");
	limit_min_a: assert property (##1 INPUT_LIMIT <= $past(cap_select) // [RQ7]
		&& INPUT_LIMIT <= $past(pin_cap_s))
		else $error("input limit above a source");
	conv_done_a: assert property (conv_done && !start_req // [RQ9]
		|=> !conv_busy && event_flags_five[`BIT_CONV_DONE])
		else $error("conversion end not flagged");
	conv_busy_a: assert property (start_req |=> conv_busy && conv_cnt == 28'h0) // [RQ19]
		else $error("start did not raise busy");
	result_load_a: assert property ($fell(conv_busy) |-> result == $past(ADC_SAMPLE)) // [RQ10]
		else $error("result not loaded at conversion end");
	set_wins_a: assert property (flags_clear && EVENT_SET[7] |=> event_flags_five[7]) // [RQ5]
		else $error("event lost against clear");

	cover_alert_cycle: cover property (!ALERT_OE ##1 ALERT_OE ##[1:50] !ALERT_OE);
	cover_conversion: cover property (start_req ##[1:1000] $fell(conv_busy));
	cover_rearm: cover property (rearm_req && ALERT_OE ##1 !ALERT_OE);
	cover_host_write: cover property (index_ev ##[1:1000] write_ev);

endmodule
`default_nettype wire

// ---- design/charger_defines.svh ----
// register offsets, field positions, reset values and timing figures
// assumes a 100 MHz system clock and the register index space of the host link
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

`define REG_OPERATING_CONTROL_A  8'h01
`define REG_CHARGE_CONTROL_B     8'h02
`define REG_CONVERTER_CONTROL    8'h11
`define REG_DEVICE_STATUS        8'h42
`define REG_RESULT_HIGH          8'h44
`define REG_RESULT_LOW           8'h45
`define REG_EVENT_FIRST          8'h51
`define REG_EVENT_FLAGS_FIVE     8'h55
`define REG_EVENT_LAST           8'h58

`define BIT_ALERT_REPEAT         3
`define BIT_ALERT_REARM          4
`define BIT_CAP_SELECT_LSB       2
`define BIT_CAP_SELECT_MSB       3
`define BIT_CONV_START           0
`define BIT_CHANNEL_LSB          4
`define BIT_CHANNEL_MSB          7
`define BIT_CONV_ACTIVE          0
`define BIT_CONV_DONE            0

`define RESET_BYTE               8'h00
`define RESET_WORD               16'h0000

`define SLAVE_ADDRESS            7'h3a

`define SYS_CLK_KHZ              100000
`define CONVERSION_TIME_MS       200
`define REPEAT_TIME_S            2
`define REARM_GAP_TIME_MS        2

`endif

// ---- design/charger_pkg.sv ----
// state types shared by the host link engine and the register bank
// assumes nothing beyond a SystemVerilog compiler
package charger_pkg;

	typedef enum logic [8:0] {
		LINK_ADDR      = 9'b000000001,
		LINK_ACK_ADDR  = 9'b000000010,
		LINK_INDEX     = 9'b000000100,
		LINK_ACK_INDEX = 9'b000001000,
		LINK_WDATA     = 9'b000010000,
		LINK_ACK_WDATA = 9'b000100000,
		LINK_RDATA     = 9'b001000000,
		LINK_RACK      = 9'b010000000,
		LINK_IDLE      = 9'b100000000
	} link_state_type;

	typedef enum logic [2:0] {
		ALERT_IDLE = 3'b001,
		ALERT_LOW  = 3'b010,
		ALERT_GAP  = 3'b100
	} alert_state_type;

endpackage

// ---- design/host_link.sv ----
// serial host link engine, clocked by the bus clock itself
// assumes link_clear is raised for every start or stop and dropped with the bus clock low
`timescale 1ns/100ps
`default_nettype none
`include "charger_defines.svh"

module host_link (
	input  wire logic                      scl,
	input  wire logic                      link_clear,
	input  wire logic                      link_rst,
	input  wire logic                      sda_in,
	output var  logic                      sda_oe,
	input  wire logic [7:0]                rd_byte,
	output var  logic [7:0]                index_byte,
	output var  logic [7:0]                write_byte,
	output var  logic                      index_toggle,
	output var  logic                      write_toggle,
	output var  logic                      read_toggle
);
	import charger_pkg::*;

	charger_pkg::link_state_type state;
	logic [2:0]                  bit_cnt;
	logic [7:0]                  shreg;
	logic [7:0]                  tx;
	logic [7:0]                  byte_in;
	logic                        last_bit;

	assign byte_in  = {shreg[6:0], sda_in};
	assign last_bit = (bit_cnt == 3'h7);

	// sampling side: the bus is read on the rising clock
	always_ff @(posedge scl or posedge link_clear) begin
		if (link_clear) begin
			state   <= LINK_ADDR;
			bit_cnt <= 3'h0;
			shreg   <= 8'h00;
			tx      <= 8'h00;
		end else begin
			case (state)
				LINK_ADDR: begin
					shreg   <= byte_in;
					bit_cnt <= bit_cnt + 3'h1;
					if (last_bit) begin
						if (byte_in[7:1] == `SLAVE_ADDRESS) begin // [RQ17]
							state <= LINK_ACK_ADDR;
						end else begin
							state <= LINK_IDLE;
						end
					end
				end
				LINK_ACK_ADDR: begin
					bit_cnt <= 3'h0;
					if (shreg[0]) begin // [RQ17]
						tx    <= rd_byte;
						state <= LINK_RDATA;
					end else begin
						state <= LINK_INDEX;
					end
				end
				LINK_INDEX: begin
					shreg   <= byte_in;
					bit_cnt <= bit_cnt + 3'h1;
					if (last_bit) begin
						state <= LINK_ACK_INDEX; // [RQ18]
					end
				end
				LINK_ACK_INDEX: begin
					bit_cnt <= 3'h0;
					state   <= LINK_WDATA;
				end
				LINK_WDATA: begin
					shreg   <= byte_in;
					bit_cnt <= bit_cnt + 3'h1;
					if (last_bit) begin
						state <= LINK_ACK_WDATA; // [RQ18]
					end
				end
				LINK_ACK_WDATA: begin
					bit_cnt <= 3'h0;
					state   <= LINK_WDATA;
				end
				LINK_RDATA: begin
					bit_cnt <= bit_cnt + 3'h1;
					if (last_bit) begin
						state <= LINK_RACK;
					end
				end
				LINK_RACK: begin
					bit_cnt <= 3'h0;
					if (!sda_in) begin
						tx    <= rd_byte;
						state <= LINK_RDATA;
					end else begin
						state <= LINK_IDLE;
					end
				end
				default: begin
					state <= LINK_IDLE;
				end
			endcase
		end
	end

	// words stay stable while their toggle crosses; never cleared by a start
	always_ff @(posedge scl or posedge link_rst) begin
		if (link_rst) begin
			index_byte   <= `RESET_BYTE;
			write_byte   <= `RESET_BYTE;
			index_toggle <= 1'b0;
			write_toggle <= 1'b0;
			read_toggle  <= 1'b0;
		end else begin
			if (state == LINK_INDEX && last_bit) begin
				index_byte   <= byte_in; // [RQ18]
				index_toggle <= ~index_toggle;
			end
			if (state == LINK_WDATA && last_bit) begin
				write_byte   <= byte_in; // [RQ18]
				write_toggle <= ~write_toggle;
			end
			if (state == LINK_RDATA && last_bit) begin
				read_toggle <= ~read_toggle;
			end
		end
	end

	// driving side: changes on the falling clock, or clears at once on link_clear
	always_ff @(negedge scl or posedge link_clear) begin
		if (link_clear) begin
			sda_oe <= 1'b0;
		end else begin
			case (state)
				LINK_ACK_ADDR, LINK_ACK_INDEX, LINK_ACK_WDATA: begin
					sda_oe <= 1'b1;
				end
				LINK_RDATA: begin
					sda_oe <= ~tx[3'h7 - bit_cnt];
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- test/host_master.sv ----
// host-side master model of the serial register link
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/100ps
`default_nettype none
`include "charger_defines.svh"

module host_master #(
	parameter int HALF = 203
) (
	output var  logic scl,
	output var  logic sda_drive,
	input  wire logic sda_line
);
	logic [7:0] got [0:7];
	logic       ack_all;

	initial begin
		scl = 1'b1;
		sda_drive = 1'b0;
		ack_all = 1'b1;
	end

	// data moves mid-low, except in the start and stop conditions, so no false start or stop is seen
	task automatic cond_start();
		#(HALF / 2) sda_drive = 1'b0;
		#(HALF / 2) scl = 1'b1;
		#HALF sda_drive = 1'b1;
		#HALF scl = 1'b0;
	endtask

	task automatic cond_stop();
		#(HALF / 2) sda_drive = 1'b1;
		#(HALF / 2) scl = 1'b1;
		#HALF sda_drive = 1'b0;
		#(4 * HALF);
	endtask

	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			#(HALF / 2) sda_drive = ~b[i];
			#(HALF / 2) scl = 1'b1;
			#HALF scl = 1'b0;
		end
		#(HALF / 2) sda_drive = 1'b0;
		#(HALF / 2) scl = 1'b1;
		#(HALF / 2) ack_all &= ~sda_line;
		#(HALF / 2) scl = 1'b0;
		#(4 * HALF);
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] b);
		sda_drive = 1'b0;
		for (int i = 0; i < 8; i++) begin
			#HALF scl = 1'b1;
			#(HALF / 2) b = {b[6:0], sda_line};
			#(HALF / 2) scl = 1'b0;
		end
		#(HALF / 2) sda_drive = ~last;
		#(HALF / 2) scl = 1'b1;
		#HALF scl = 1'b0;
		#(HALF / 2) sda_drive = 1'b0;
		#(4 * HALF);
	endtask

	task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d);
		cond_start();
		send_byte({a, 1'b0});
		send_byte(idx);
		send_byte(d);
		cond_stop();
	endtask

	// index write, repeated start, then a burst ending in a refusal
	task automatic read_regs(input logic [7:0] idx, input int n);
		cond_start();
		send_byte({`SLAVE_ADDRESS, 1'b0});
		send_byte(idx);
		cond_start();
		send_byte({`SLAVE_ADDRESS, 1'b1});
		for (int i = 0; i < n; i++)
			recv_byte(i == n - 1, got[i]);
		cond_stop();
	endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the charger register bank and alert line
// assumes the host model owns the link clock and the data wire
`timescale 1ns/100ps
`default_nettype none
`include "charger_defines.svh"

module testbench;
	localparam int CONV = 3000;
	localparam int REP = 4000;
	localparam int GAP = 100;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        scl, sda_drive, sda_out, sda_oe, alert_out, alert_oe;
	logic [7:1]  event_set = '0;
	logic [15:0] adc_sample = '0;
	logic [1:0]  pin_cap = '0, input_limit, c;
	logic [3:0]  adc_channel, ch;
	wire         sda_line = ~(sda_drive | (sda_oe & ~sda_out));
	int          fail_count = 0, checks = 0;
	int          low_len = 0, gap_len = 0, last_low = 0, last_gap = 0;
	int          model [int];

	always #5 clk_sys = ~clk_sys;

	charger_alert_adc #(.CONVERSION_CYCLES(28'(CONV)), .REPEAT_CYCLES(28'(REP)),
		.REARM_CYCLES(28'(GAP))) dut_u (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
		.SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.ALERT_OUT(alert_out), .ALERT_OE(alert_oe), .EVENT_SET(event_set),
		.ADC_SAMPLE(adc_sample), .ADC_CHANNEL(adc_channel),
		.PIN_CURRENT_CAP(pin_cap), .INPUT_LIMIT(input_limit));

	host_master #(.HALF(203)) host_u (.scl(scl), .sda_drive(sda_drive), .sda_line(sda_line));

	// lengths of the last low and released spans of the alert line
	always @(posedge clk_sys) begin
		if (alert_oe === 1'b1) begin
			if (gap_len > 0)
				last_gap = gap_len;
			gap_len = 0;
			low_len++;
		end else begin
			if (low_len > 0)
				last_low = low_len;
			low_len = 0;
			gap_len++;
		end
	end

	task automatic print_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// spans are counted from our own sampling, so allow two cycles either way
	task automatic check_span(input string name, input int exp, input int got);
		// span counters close one edge after the line turns, so let them settle
		repeat (2) @(posedge clk_sys);
		got = (name == "repeat low") ? last_low : last_gap;
		checks++;
		if (got > exp + 2 || got + 2 < exp) begin
			fail_count++;
			$display("ERROR %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	function automatic logic [7:0] exp_reg(input int a);
		return model.exists(a) ? 8'(model[a]) : 8'h00;
	endfunction

	task automatic read_cmp(input logic [7:0] idx, input int n);
		host_u.ack_all = 1'b1;
		host_u.read_regs(idx, n);
		check_val("read ack", 16'h0001, 16'(host_u.ack_all));
		for (int i = 0; i < n; i++)
			check_val($sformatf("reg %h", idx + i), 16'(exp_reg(idx + i)), 16'(host_u.got[i]));
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		host_u.ack_all = 1'b1;
		host_u.write_reg(`SLAVE_ADDRESS, idx, d);
		check_val("write ack", 16'h0001, 16'(host_u.ack_all));
	endtask

	task automatic wait_alert(input logic lvl, input int max);
		for (int i = 0; i < max && alert_oe !== lvl; i++)
			@(negedge clk_sys);
		check_val("alert", 16'(lvl), 16'(alert_oe));
		check_val("alert level", 16'h0000, 16'(alert_out));
	endtask

	task automatic pulse(input logic [7:1] e);
		@(posedge clk_sys) event_set <= e;
		@(posedge clk_sys) event_set <= '0;
		model['h55] = exp_reg('h55) | {e, 1'b0};
	endtask

	task automatic read_events();
		read_cmp(8'h51, 8);
		model['h55] = 0;
		wait_alert(1'b0, 10);
	endtask

	initial begin
		void'($urandom(9));
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (12) @(posedge clk_sys);
		read_cmp(8'h01, 2);
		read_cmp(8'h11, 1);
		read_cmp(8'h42, 4);
		check_val("alert idle", 16'h0000, 16'(alert_oe));
		for (int k = 0; k < 3; k++) begin
			c = 2'($urandom());
			@(posedge clk_sys) pin_cap <= 2'($urandom());
			wr(8'h02, {4'h0, c, 2'b00});
			model['h02] = {c, 2'b00};
			check_val("limit", 16'((c < pin_cap) ? c : pin_cap), 16'(input_limit));
		end
		// a foreign address must be refused and change nothing
		host_u.ack_all = 1'b1;
		host_u.write_reg(`SLAVE_ADDRESS ^ 7'h01, 8'h02, 8'h0c);
		check_val("foreign ack", 16'h0000, 16'(host_u.ack_all));
		read_cmp(8'h01, 2);
		ch = 4'($urandom());
		@(posedge clk_sys) adc_sample <= 16'($urandom());
		// current settings are host-side only here, taken as already high enough
		wr(8'h11, {ch, 4'h1});
		model['h11] = {ch, 4'h0};
		model['h42] = 1;
		check_val("channel", 16'(ch), 16'(adc_channel));
		read_cmp(8'h42, 1);
		wait_alert(1'b1, CONV);
		model['h42] = 0;
		model['h44] = adc_sample[15:8];
		model['h45] = adc_sample[7:0];
		model['h55] = 1;
		read_cmp(8'h11, 1);
		read_cmp(8'h42, 4);
		read_events();
		for (int k = 0; k < 2; k++) begin
			pulse(7'($urandom()) | 7'h01);
			wait_alert(1'b1, 4);
			read_events();
		end
		wr(8'h01, 8'h08);
		model['h01] = 8'h08;
		pulse(7'h40);
		wait_alert(1'b1, 4);
		wait_alert(1'b0, REP + 10);
		check_span("repeat low", REP, last_low);
		wait_alert(1'b1, GAP + 10);
		check_span("repeat gap", GAP, last_gap);
		read_cmp(8'h01, 1);
		read_events();
		pulse(7'h02);
		wait_alert(1'b1, 4);
		wr(8'h01, 8'h10);
		model['h01] = 0;
		wait_alert(1'b1, GAP + 10);
		check_span("rearm gap", GAP, last_gap);
		read_cmp(8'h01, 1);
		read_events();
		print_verdict();
	end

	initial begin
		#1_000_000;
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
